// >>> rtl/xdd_pkg.sv
// Constants and types shared by the xor and divide datapath
package xdd_pkg;
  // Opcodes
  localparam logic [7:0] OP_XA_IMM = 8'h88;
  localparam logic [7:0] OP_XA_DIR = 8'h98;
  localparam logic [7:0] OP_XA_EXT = 8'hB8;
  localparam logic [7:0] OP_XA_IDX = 8'hA8;
  localparam logic [7:0] OP_XB_IMM = 8'hC8;
  localparam logic [7:0] OP_XB_DIR = 8'hD8;
  localparam logic [7:0] OP_XB_EXT = 8'hF8;
  localparam logic [7:0] OP_XB_IDX = 8'hE8;
  localparam logic [7:0] OP_PRE_Y  = 8'h18;
  localparam logic [7:0] OP_FRAC   = 8'h03;
  localparam logic [7:0] OP_INT    = 8'h02;
  // Bit 6 of an xor opcode selects accumulator B
  localparam int unsigned OP_SEL_B_BIT = 6;

  // Condition code bit positions
  localparam int unsigned CCR_C = 0;
  localparam int unsigned CCR_V = 1;
  localparam int unsigned CCR_Z = 2;
  localparam int unsigned CCR_N = 3;

  // Fixed addresses and values
  localparam logic [15:0] IDLE_ADDR = 16'hFFFF;
  localparam logic [7:0]  ZERO_PAGE = 8'h00;
  localparam logic [15:0] QUO_SAT   = 16'hFFFF;

  // Reset values
  localparam logic [15:0] RST_ADDR = 16'hFFFF;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Divide timing in bus cycles
  localparam int unsigned DIV_FIRST_CYC = 3;
  localparam int unsigned DIV_STEPS     = 16;
  localparam int unsigned DIV_LAST_CYC  = 41;

  typedef enum logic [2:0] {
    XDD_M_IMM, XDD_M_DIR, XDD_M_EXT, XDD_M_IDX, XDD_M_PRE, XDD_M_FRAC, XDD_M_INT, XDD_M_BAD
  } xdd_mode_t;

  typedef enum logic [2:0] {
    XDD_S_IDLE, XDD_S_FETCH, XDD_S_BYTE2, XDD_S_ADDR_LO, XDD_S_OFFS, XDD_S_DUMMY, XDD_S_OPER,
    XDD_S_DIV
  } xdd_state_t;
endpackage

// >>> rtl/xdd_datapath.sv
// Exclusive-OR and divide execution datapath with its own bus sequence
// Notes on behaviour
// RULE_01 - Xor replaces each selected accumulator bit with bit xor operand bit.
// RULE_02 - Xor into A opcodes: 88 imm, 98 dir, B8 ext, A8 X, 18 A8 Y.
// RULE_03 - Xor into B opcodes: C8 imm, D8 dir, F8 ext, E8 X, 18 E8 Y.
// RULE_04 - Xor takes 2/3/4/4/5 cycles; indexed forms insert idle FFFF read first.
// RULE_05 - Fractional divide: D over X, quotient to X, remainder to D.
// RULE_06 - Fractional quotient equals numerator times 2^16 divided by denominator.
// RULE_07 - Fractional divide with zero or small denominator loads FFFF into X.
// RULE_08 - Software keeps fractional numerator below the denominator.
// RULE_09 - Fractional divide sets zero flag exactly when quotient is 0000.
// RULE_10 - Fractional divide sets overflow when denominator not above numerator.
// RULE_11 - Fractional divide sets carry for zero denominator; other flags kept.
// RULE_12 - Integer divide: D over X, quotient to X, remainder to D.
// RULE_13 - Integer divide by zero loads FFFF into X; remainder undefined.
// RULE_14 - Integer divide clears overflow; carry set only for zero denominator.
// RULE_15 - Opcodes 03 and 02 divide in 41 cycles, idle FFFF reads from cycle 3.
// RULE_16 - Xor sets N from bit 7, Z on zero, clears V, keeps C.
// RULE_17 - Double accumulator is A as high byte and B as low byte.
module xdd_datapath #(
  parameter int unsigned DIV_CYCLES = xdd_pkg::DIV_LAST_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  acc_a_in,
  input  wire logic [7:0]  acc_b_in,
  input  wire logic [15:0] index_register_x_in,
  input  wire logic [15:0] iy_in,
  input  wire logic [7:0]  ccr_in,
  input  wire logic [7:0]  bus_rdata,
  output logic      [15:0] bus_addr,
  output logic             bus_rd,
  output logic             busy,
  output logic             done,
  output logic             bad_op,
  output logic      [7:0]  acc_a,
  output logic      [7:0]  acc_b,
  output logic      [15:0] index_register_x,
  output logic      [7:0]  ccr
);

  if (DIV_CYCLES < xdd_pkg::DIV_FIRST_CYC + xdd_pkg::DIV_STEPS || DIV_CYCLES > 63) begin
    $error("DIV_CYCLES out of range");
  end
  localparam logic [5:0] DIV_END  = 6'(DIV_CYCLES);
  localparam logic [5:0] STEP_END = 6'(xdd_pkg::DIV_FIRST_CYC + xdd_pkg::DIV_STEPS - 1);
  // Opcode to addressing mode
  function automatic xdd_pkg::xdd_mode_t xdd_decode(input logic [7:0] op);
    case (op)
      xdd_pkg::OP_XA_IMM, xdd_pkg::OP_XB_IMM: xdd_decode = xdd_pkg::XDD_M_IMM; // see RULE_02 RULE_03
      xdd_pkg::OP_XA_DIR, xdd_pkg::OP_XB_DIR: xdd_decode = xdd_pkg::XDD_M_DIR; // see RULE_02 RULE_03
      xdd_pkg::OP_XA_EXT, xdd_pkg::OP_XB_EXT: xdd_decode = xdd_pkg::XDD_M_EXT; // see RULE_02 RULE_03
      xdd_pkg::OP_XA_IDX, xdd_pkg::OP_XB_IDX: xdd_decode = xdd_pkg::XDD_M_IDX; // see RULE_02 RULE_03
      xdd_pkg::OP_PRE_Y: xdd_decode = xdd_pkg::XDD_M_PRE;
      xdd_pkg::OP_FRAC:  xdd_decode = xdd_pkg::XDD_M_FRAC; // see RULE_15
      xdd_pkg::OP_INT:   xdd_decode = xdd_pkg::XDD_M_INT; // see RULE_15
      default:           xdd_decode = xdd_pkg::XDD_M_BAD;
    endcase
  endfunction
  // One restoring divide step: returns remainder and shifted quotient
  function automatic logic [32:0] xdd_div_step(input logic [16:0] rem, input logic [15:0] quo,
                                               input logic [15:0] den);
    logic [16:0] trial;
    trial = {rem[15:0], quo[15]};
    if (trial >= {1'b0, den}) begin
      xdd_div_step = {17'(trial - {1'b0, den}), quo[14:0], 1'b1};
    end else begin
      xdd_div_step = {trial, quo[14:0], 1'b0};
    end
  endfunction
  xdd_pkg::xdd_state_t st_q;
  xdd_pkg::xdd_state_t st_d;
  xdd_pkg::xdd_mode_t  mode_q;
  xdd_pkg::xdd_mode_t  mode_d;
  logic        sel_b_q;
  logic        sel_b_d;
  logic [5:0]  cnt_q;
  logic [5:0]  cnt_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [15:0] iy_q;
  logic [15:0] iy_d;
  logic [7:0]  lat_q;
  logic [7:0]  lat_d;
  logic [16:0] rem_q;
  logic [16:0] rem_d;
  logic [15:0] quo_q;
  logic [15:0] quo_d;
  logic        ovf_q;
  logic        ovf_d;
  logic        den0_q;
  logic        den0_d;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic        rd_q;
  logic        rd_d;
  logic        busy_q;
  logic        busy_d;
  logic        done_q;
  logic        done_d;
  logic        bad_q;
  logic        bad_d;
  logic [7:0]  a_q;
  logic [7:0]  a_d;
  logic [7:0]  b_q;
  logic [7:0]  b_d;
  logic [15:0] x_q;
  logic [15:0] x_d;
  logic [7:0]  ccr_q;
  logic [7:0]  ccr_d;

  always_comb begin
    logic        finish;
    logic        do_xor;
    logic [7:0]  res;
    logic [15:0] quot;
    logic [32:0] step;
    finish = 1'b0;
    do_xor = 1'b0;
    res    = xdd_pkg::RST_BYTE;
    quot   = xdd_pkg::RST_WORD;
    step   = 33'(0);
    st_d   = st_q;
    mode_d = mode_q;
    sel_b_d = sel_b_q;
    cnt_d  = 6'(cnt_q + 6'h01);
    pc_d   = pc_q;
    iy_d   = iy_q;
    lat_d  = lat_q;
    rem_d  = rem_q;
    quo_d  = quo_q;
    ovf_d  = ovf_q;
    den0_d = den0_q;
    addr_d = xdd_pkg::IDLE_ADDR;
    rd_d   = 1'b1;
    busy_d = 1'b1;
    done_d = 1'b0;
    bad_d  = 1'b0;
    a_d    = a_q;
    b_d    = b_q;
    x_d    = x_q;
    ccr_d  = ccr_q;
    case (st_q)
      xdd_pkg::XDD_S_IDLE: begin
        rd_d   = 1'b0;
        busy_d = 1'b0;
        cnt_d  = 6'h00;
        if (start) begin
          st_d   = xdd_pkg::XDD_S_FETCH;
          addr_d = pc_in;
          rd_d   = 1'b1;
          busy_d = 1'b1;
          cnt_d  = 6'h01;
          pc_d   = pc_in;
          iy_d   = iy_in;
          a_d    = acc_a_in;
          b_d    = acc_b_in;
          x_d    = index_register_x_in;
          ccr_d  = ccr_in;
        end
      end
      xdd_pkg::XDD_S_FETCH: begin
        mode_d  = xdd_decode(bus_rdata);
        sel_b_d = bus_rdata[xdd_pkg::OP_SEL_B_BIT];
        st_d    = xdd_pkg::XDD_S_BYTE2;
        addr_d  = 16'(pc_q + 16'h0001);
      end
      xdd_pkg::XDD_S_BYTE2: begin
        case (mode_q)
          xdd_pkg::XDD_M_IMM: begin
            do_xor = 1'b1; // see RULE_04
          end
          xdd_pkg::XDD_M_DIR: begin
            st_d   = xdd_pkg::XDD_S_OPER;
            addr_d = {xdd_pkg::ZERO_PAGE, bus_rdata}; // see RULE_04
          end
          xdd_pkg::XDD_M_EXT: begin
            lat_d  = bus_rdata;
            st_d   = xdd_pkg::XDD_S_ADDR_LO;
            addr_d = 16'(pc_q + 16'h0002);
          end
          xdd_pkg::XDD_M_IDX: begin
            lat_d = bus_rdata;
            st_d  = xdd_pkg::XDD_S_DUMMY; // see RULE_04
          end
          xdd_pkg::XDD_M_PRE: begin
            if (bus_rdata == xdd_pkg::OP_XA_IDX || bus_rdata == xdd_pkg::OP_XB_IDX) begin
              sel_b_d = bus_rdata[xdd_pkg::OP_SEL_B_BIT]; // see RULE_02 RULE_03
              st_d    = xdd_pkg::XDD_S_OFFS;
              addr_d  = 16'(pc_q + 16'h0002);
            end else begin
              bad_d  = 1'b1;
              finish = 1'b1;
            end
          end
          xdd_pkg::XDD_M_FRAC: begin
            // Numerator shifted up 16: start with it as the partial remainder
            rem_d  = {1'b0, a_q, b_q}; // see RULE_06 RULE_17
            quo_d  = xdd_pkg::RST_WORD;
            den0_d = (x_q == xdd_pkg::RST_WORD);
            ovf_d  = (x_q <= {a_q, b_q}); // see RULE_10
            st_d   = xdd_pkg::XDD_S_DIV; // see RULE_15
          end
          xdd_pkg::XDD_M_INT: begin
            rem_d  = 17'(0);
            quo_d  = {a_q, b_q}; // see RULE_12 RULE_17
            den0_d = (x_q == xdd_pkg::RST_WORD);
            ovf_d  = 1'b0;
            st_d   = xdd_pkg::XDD_S_DIV; // see RULE_15
          end
          default: begin
            bad_d  = 1'b1;
            finish = 1'b1;
          end
        endcase
      end
      xdd_pkg::XDD_S_ADDR_LO: begin
        st_d   = xdd_pkg::XDD_S_OPER;
        addr_d = {lat_q, bus_rdata}; // see RULE_04
      end
      xdd_pkg::XDD_S_OFFS: begin
        lat_d = bus_rdata;
        st_d  = xdd_pkg::XDD_S_DUMMY; // see RULE_04
      end
      xdd_pkg::XDD_S_DUMMY: begin
        st_d = xdd_pkg::XDD_S_OPER;
        if (mode_q == xdd_pkg::XDD_M_PRE) begin
          addr_d = 16'(iy_q + {8'h00, lat_q}); // see RULE_04
        end else begin
          addr_d = 16'(x_q + {8'h00, lat_q}); // see RULE_04
        end
      end
      xdd_pkg::XDD_S_OPER: begin
        do_xor = 1'b1;
      end
      xdd_pkg::XDD_S_DIV: begin
        if (cnt_q <= STEP_END) begin
          step  = xdd_div_step(rem_q, quo_q, x_q); // see RULE_05 RULE_12
          rem_d = step[32:16];
          quo_d = step[15:0];
        end
        if (cnt_q == DIV_END) begin
          finish = 1'b1; // see RULE_15
          if (den0_q || ovf_q) begin
            quot = xdd_pkg::QUO_SAT; // see RULE_07 RULE_13
          end else begin
            quot = quo_q; // see RULE_06 RULE_12
          end
          x_d = quot;
          a_d = rem_q[15:8]; // see RULE_05 RULE_17
          b_d = rem_q[7:0];
          ccr_d[xdd_pkg::CCR_Z] = (quot == xdd_pkg::RST_WORD); // see RULE_09
          ccr_d[xdd_pkg::CCR_V] = ovf_q; // see RULE_10 RULE_14
          ccr_d[xdd_pkg::CCR_C] = den0_q; // see RULE_11 RULE_14
        end
      end
      default: begin
        finish = 1'b1;
      end
    endcase
    if (do_xor) begin
      finish = 1'b1;
      res = (sel_b_q ? b_q : a_q) ^ bus_rdata; // see RULE_01
      if (sel_b_q) begin
        b_d = res;
      end else begin
        a_d = res;
      end
      ccr_d[xdd_pkg::CCR_N] = res[7]; // see RULE_16
      ccr_d[xdd_pkg::CCR_Z] = (res == xdd_pkg::RST_BYTE);
      ccr_d[xdd_pkg::CCR_V] = 1'b0;
    end
    if (finish) begin
      st_d   = xdd_pkg::XDD_S_IDLE;
      addr_d = xdd_pkg::IDLE_ADDR;
      rd_d   = 1'b0;
      busy_d = 1'b0;
      done_d = 1'b1;
      cnt_d  = 6'h00;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= xdd_pkg::XDD_S_IDLE;
      mode_q  <= xdd_pkg::XDD_M_BAD;
      sel_b_q <= 1'b0;
      cnt_q   <= 6'h00;
      pc_q    <= xdd_pkg::RST_WORD;
      iy_q    <= xdd_pkg::RST_WORD;
      lat_q   <= xdd_pkg::RST_BYTE;
      rem_q   <= 17'(0);
      quo_q   <= xdd_pkg::RST_WORD;
      ovf_q   <= 1'b0;
      den0_q  <= 1'b0;
      addr_q  <= xdd_pkg::RST_ADDR;
      rd_q    <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      bad_q   <= 1'b0;
      a_q     <= xdd_pkg::RST_BYTE;
      b_q     <= xdd_pkg::RST_BYTE;
      x_q     <= xdd_pkg::RST_WORD;
      ccr_q   <= xdd_pkg::RST_BYTE;
    end else begin
      st_q    <= st_d;
      mode_q  <= mode_d;
      sel_b_q <= sel_b_d;
      cnt_q   <= cnt_d;
      pc_q    <= pc_d;
      iy_q    <= iy_d;
      lat_q   <= lat_d;
      rem_q   <= rem_d;
      quo_q   <= quo_d;
      ovf_q   <= ovf_d;
      den0_q  <= den0_d;
      addr_q  <= addr_d;
      rd_q    <= rd_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      bad_q   <= bad_d;
      a_q     <= a_d;
      b_q     <= b_d;
      x_q     <= x_d;
      ccr_q   <= ccr_d;
    end
  end
  assign bus_addr         = addr_q;
  assign bus_rd           = rd_q;
  assign busy             = busy_q;
  assign done             = done_q;
  assign bad_op           = bad_q;
  assign acc_a            = a_q;
  assign acc_b            = b_q;
  assign index_register_x = x_q;
  assign ccr              = ccr_q;

endmodule // xdd_datapath

// >>> sim/xdd_checker.sv
// Assertion checker for the xor and divide datapath
module xdd_checker #(
  parameter int unsigned DIV_CYCLES = 41
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        start,
  input wire logic [15:0] index_register_x_in,
  input wire logic [7:0]  bus_rdata,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        bad_op,
  input wire logic [7:0]  acc_a,
  input wire logic [7:0]  acc_b,
  input wire logic [15:0] index_register_x,
  input wire logic [7:0]  ccr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  op_q;
  logic [15:0] den_q;
  logic [6:0]  cnt_q;
  logic        busy_q;
  logic        fin;
  logic        is_div;
  assign fin    = done && !bad_op;
  assign is_div = op_q == xdd_pkg::OP_FRAC || op_q == xdd_pkg::OP_INT;
  // Opcode, denominator and busy length of the running instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_q   <= 8'h00;
      den_q  <= 16'h0000;
      cnt_q  <= 7'h00;
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
      if (start && !busy) begin
        den_q <= index_register_x_in;
      end
      if (busy && !busy_q) begin
        op_q  <= bus_rdata;
        cnt_q <= 7'h01;
      end else if (busy) begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end
  function automatic int xor_len(logic [7:0] op);
    if (op == xdd_pkg::OP_PRE_Y) return 5;
    if (op[5:4] == 2'b00) return 2;
    return op[5:4] == 2'b01 ? 3 : 4;
  endfunction
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_div_go;
    $rose(busy) && (bus_rdata == xdd_pkg::OP_FRAC || bus_rdata == xdd_pkg::OP_INT);
  endsequence
  sequence s_idle_run;
    (bus_rd && bus_addr == xdd_pkg::IDLE_ADDR) [*8];
  endsequence
  sequence s_dir_go;
    $rose(busy) && (bus_rdata == xdd_pkg::OP_XA_DIR || bus_rdata == xdd_pkg::OP_XB_DIR);
  endsequence
  property p_div_idle;
    s_div_go |-> ##2 s_idle_run;
  endproperty
  a_div_idle: assert property (p_div_idle) else $error("divide idle reads wrong");
  property p_div_len;
    fin && is_div |-> cnt_q == DIV_CYCLES;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length wrong");
  property p_xor_len;
    fin && op_q[3:0] == 4'h8 |-> cnt_q == xor_len(op_q);
  endproperty
  a_xor_len: assert property (p_xor_len) else $error("xor length wrong");
  property p_dir;
    s_dir_go |-> ##2 bus_addr == {xdd_pkg::ZERO_PAGE, $past(bus_rdata)};
  endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");
  property p_frac_z;
    fin && op_q == xdd_pkg::OP_FRAC |-> ccr[xdd_pkg::CCR_Z] == (index_register_x == 16'h0000);
  endproperty
  a_frac_z: assert property (p_frac_z) else $error("zero flag wrong");
  property p_div_c;
    fin && is_div |-> ccr[xdd_pkg::CCR_C] == (den_q == 16'h0000);
  endproperty
  a_div_c: assert property (p_div_c) else $error("carry flag wrong");
  property p_int_v;
    fin && op_q == xdd_pkg::OP_INT |-> !ccr[xdd_pkg::CCR_V];
  endproperty
  a_int_v: assert property (p_int_v) else $error("overflow flag set");
  property p_xor_flags;
    fin && op_q[3:0] == 4'h8 && op_q != xdd_pkg::OP_PRE_Y
      |-> !ccr[xdd_pkg::CCR_V] && ccr[xdd_pkg::CCR_N] == (op_q[6] ? acc_b[7] : acc_a[7]);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong");
endmodule // xdd_checker

bind xdd_datapath xdd_checker #(.DIV_CYCLES(DIV_CYCLES)) xdd_checker_inst (
  .clk(clk), .rst(rst), .start(start), .index_register_x_in(index_register_x_in),
  .bus_rdata(bus_rdata),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .busy(busy), .done(done), .bad_op(bad_op),
  .acc_a(acc_a), .acc_b(acc_b), .index_register_x(index_register_x), .ccr(ccr)
);

// >>> sim/xdd_mem_model.sv
// Memory model answering the datapath's read cycles
module xdd_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [65536];
  logic [7:0] last_q = 8'h00;
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'hA5 ^ i[7:0];
    end
  end
  // Released bus shows the inverse of the last byte
  always_comb begin
    bus_rdata = bus_rd ? mem[bus_addr] : ~last_q;
  end
  always @(posedge clk) begin
    if (bus_rd) begin
      last_q <= mem[bus_addr];
    end
  end
endmodule // xdd_mem_model

// >>> sim/tb.sv
// Testbench for the xor and divide datapath
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst;
  logic        start;
  logic [15:0] pc_in;
  logic [7:0]  acc_a_in;
  logic [7:0]  acc_b_in;
  logic [15:0] index_register_x_in;
  logic [15:0] iy_in;
  logic [7:0]  ccr_in;
  logic [7:0]  bus_rdata;
  logic [15:0] bus_addr;
  logic        bus_rd;
  logic        busy;
  logic        done;
  logic        bad_op;
  logic [7:0]  acc_a;
  logic [7:0]  acc_b;
  logic [15:0] index_register_x;
  logic [7:0]  ccr;
  int          err_count;
  int          cmp_count;
  int          cyc;
  xdd_datapath #(.DIV_CYCLES(41)) xdd_datapath_inst (
    .clk(clk), .rst(rst), .start(start), .pc_in(pc_in), .acc_a_in(acc_a_in),
    .acc_b_in(acc_b_in), .index_register_x_in(index_register_x_in), .iy_in(iy_in),
    .ccr_in(ccr_in),
    .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_rd(bus_rd), .busy(busy),
    .done(done), .bad_op(bad_op), .acc_a(acc_a), .acc_b(acc_b),
    .index_register_x(index_register_x), .ccr(ccr)
  );
  xdd_mem_model xdd_mem_model_inst (
    .clk(clk), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata)
  );
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    xdd_mem_model_inst.mem[a] = v;
  endtask
  // One start pulse; n ends as the cycle number of done
  task automatic exec(output int n);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_xor();
    logic [7:0] ops [8] = '{8'h88, 8'h98, 8'hB8, 8'hA8, 8'hC8, 8'hD8, 8'hF8, 8'hE8};
    int         lens [5] = '{3, 4, 5, 5, 6};
    logic [7:0] op;
    logic [7:0] a0;
    logic [7:0] r;
    int         s;
    int         m;
    int         n;
    for (int k = 0; k < 10; k++) begin
      s = k / 5;
      m = k % 5;
      op = ops[s * 4 + (m > 3 ? 3 : m)];
      a0 = m == 1 ? 8'h5A : 8'hF0;
      acc_a_in = s ? 8'h33 : a0;
      acc_b_in = s ? a0 : 8'h33;
      r = a0 ^ 8'h5A;
      wr(16'h1000, m == 4 ? 8'h18 : op);
      wr(16'h1001, m == 0 ? 8'h5A : m == 4 ? op : m == 2 ? 8'h20 : 8'h40);
      wr(16'h1002, m == 4 ? 8'h50 : 8'h40);
      wr(16'h0040, m == 1 ? 8'h5A : 8'h00);
      wr(16'h2040, 8'h5A);
      exec(n);
      check(16'(n), 16'(lens[m]));
      check(bad_op, 1'b0);
      check(s ? acc_b : acc_a, r);
      check(s ? acc_a : acc_b, 8'h33);
      check(ccr, {ccr_in[7:4], r[7], r == 8'h00, 1'b0, ccr_in[0]});
    end
  endtask
  task automatic t_div();
    // Rows 0 and 3 keep the numerator below the denominator
    logic [15:0] dd [6] = '{16'h0001, 16'h0003, 16'h1234, 16'h0000, 16'h0007, 16'hABCD};
    logic [15:0] dx [6] = '{16'h0002, 16'h0003, 16'h0000, 16'h0005, 16'h0002, 16'h0000};
    logic [31:0] num;
    logic [15:0] q;
    logic        f;
    logic        sat;
    int          n;
    for (int i = 0; i < 6; i++) begin
      f = i < 4;
      {acc_a_in, acc_b_in} = dd[i];
      index_register_x_in = dx[i];
      ccr_in = 8'hAA;
      wr(16'h1000, f ? 8'h03 : 8'h02);
      num = f ? {dd[i], 16'h0000} : {16'h0000, dd[i]};
      sat = dx[i] == 16'h0000 || (f && dx[i] <= dd[i]);
      q = sat ? 16'hFFFF : 16'(num / dx[i]);
      exec(n);
      check(16'(n), 16'h002A);
      check(index_register_x, q);
      if (!sat) check({acc_a, acc_b}, 16'(num % dx[i]));
      check(ccr, {ccr_in[7:3], q == 16'h0000, f && sat, dx[i] == 16'h0000});
    end
  endtask
  task automatic t_bad();
    int n;
    acc_a_in = 8'h12;
    wr(16'h1000, 8'h01);
    exec(n);
    check(bad_op, 1'b1);
    check(16'(n), 16'h0003);
    check(acc_a, 8'h12);
    wr(16'h1000, 8'h18);
    wr(16'h1001, 8'h01);
    exec(n);
    check(bad_op, 1'b1);
    check(16'(n), 16'h0003);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    start = 1'b0;
    pc_in = 16'h1000;
    acc_a_in = 8'h00;
    acc_b_in = 8'h00;
    index_register_x_in = 16'h2000;
    iy_in = 16'h1FF0;
    ccr_in = 8'h03;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_xor();
    t_div();
    t_bad();
    close_out();
  end
endmodule // tb
